// [src/fspd_regs.vh]
// Purpose: constants of the flash suspend and power-down control
// Assumes: core clock of 250 MHz, times given in ns
// Notes:   definitions only, no logic
`ifndef FSPD_REGS_VH
`define FSPD_REGS_VH

// clock period in ns
`define FSPD_CLK_NS        4

// opcodes handled locally
`define FSPD_OP_SUSPEND    8'h75
`define FSPD_OP_RESUME     8'h7a
`define FSPD_OP_PWRDOWN    8'hb9
`define FSPD_OP_RELEASE    8'hab

// opcodes refused while suspended
`define FSPD_OP_WRSR1      8'h01
`define FSPD_OP_WRSR2      8'h31
`define FSPD_OP_PP         8'h02
`define FSPD_OP_QPP        8'h32
`define FSPD_OP_SE         8'h20
`define FSPD_OP_BE32       8'h52
`define FSPD_OP_BE64       8'hd8
`define FSPD_OP_CE1        8'hc7
`define FSPD_OP_CE2        8'h60

// bit counts within a frame
`define FSPD_OPC_BITS      6'h08
`define FSPD_ID_START      6'h20
`define FSPD_CNT_MAX       6'h28

// kind of the running engine cycle
`define FSPD_KIND_NONE     2'h0
`define FSPD_KIND_SECBLK   2'h1
`define FSPD_KIND_PAGE     2'h2
`define FSPD_KIND_CHIP     2'h3

// timing, ns as given and derived cycle counts (rounded down)
`define FSPD_T_SUS_NS      20000
`define FSPD_T_DP_NS       3000
`define FSPD_T_RES1_NS     3000
`define FSPD_T_RES2_NS     1800
`define FSPD_T_RESUME_NS   200
`define FSPD_SUS_CYC       (`FSPD_T_SUS_NS / `FSPD_CLK_NS)
`define FSPD_DP_CYC        (`FSPD_T_DP_NS / `FSPD_CLK_NS)
`define FSPD_RES1_CYC      (`FSPD_T_RES1_NS / `FSPD_CLK_NS)
`define FSPD_RES2_CYC      (`FSPD_T_RES2_NS / `FSPD_CLK_NS)

// identifier byte, value arbitrary
`define FSPD_DEV_ID        8'h5a

// reset values
`define FSPD_RST_FLAG      1'b0
`define FSPD_RST_OBIT      3'h7

`endif

// [src/fspd_ctrl.v]
// Purpose: suspend/resume and deep power-down control of a serial flash
// Assumes: link pins are asynchronous and sampled by clk_i; link clock
//          is slow enough (48 ns) for edge detection at 4 ns
// Notes:   the erase/program engine lives outside and reports through
//          core_*; core_busy_i must follow resume_req_o within a cycle
`timescale 1ns/10ps
`include "fspd_regs.vh"
`default_nettype none

module fspd_ctrl
#(
   parameter integer SUS_CYC = `FSPD_SUS_CYC
)
(
   // clock and reset
   input  wire        clk_i,
   input  wire        rst_i,
   // serial link pins
   input  wire        cs_n_i,
   input  wire        sclk_i,
   input  wire [3:0]  dq_i,
   output wire [3:0]  dq_o,
   output wire [3:0]  dq_oe_o,
   // mode
   input  wire        quad_opcode_mode_i,
   // erase/program engine
   input  wire        core_busy_i,
   input  wire [1:0]  core_kind_i,
   input  wire        core_halted_i,
   input  wire [11:0] core_sector_i,
   input  wire [11:0] rd_sector_i,
   output wire        suspend_req_o,
   output wire        resume_req_o,
   // decoded opcodes for the rest of the device
   output wire [7:0]  opcode_o,
   output wire        opcode_vld_o,
   // status
   output wire        busy_flag_o,
   output wire        suspended_flag_o,
   output wire        powerdown_o,
   output wire        rd_allow_o
);

   localparam [1:0] ST_NORM  = 2'h0;
   localparam [1:0] ST_ENTER = 2'h1;
   localparam [1:0] ST_PD    = 2'h2;
   localparam [1:0] ST_REL   = 2'h3;

   // identifier kept at byte width so single bits can be picked
   localparam [7:0]  DEV_ID    = `FSPD_DEV_ID;
   // release wait with identifier starts part way into the full wait
   localparam [15:0] REL2_TMR  = `FSPD_RES1_CYC - `FSPD_RES2_CYC;

   // program, erase and status-write opcodes
   function is_pe;
      input [7:0] op;
      begin
         case (op)
            `FSPD_OP_WRSR1, `FSPD_OP_WRSR2, `FSPD_OP_PP, `FSPD_OP_QPP,
            `FSPD_OP_SE, `FSPD_OP_BE32, `FSPD_OP_BE64,
            `FSPD_OP_CE1, `FSPD_OP_CE2:
               is_pe = 1'b1;
            default:
               is_pe = 1'b0;
         endcase
      end
   endfunction

   // opcodes handled here rather than forwarded
   function is_local;
      input [7:0] op;
      begin
         is_local = (op == `FSPD_OP_SUSPEND) || (op == `FSPD_OP_RESUME) ||
                    (op == `FSPD_OP_PWRDOWN) || (op == `FSPD_OP_RELEASE);
      end
   endfunction

   // synchronisers
   reg        cs_s1_q;
   reg        cs_s2_q;
   reg        cs_s3_q;
   reg        ck_s1_q;
   reg        ck_s2_q;
   reg        ck_s3_q;
   reg [3:0]  dq_s1_q;
   reg [3:0]  dq_s2_q;

   // frame state
   reg [7:0]  sh_q;
   reg [5:0]  cnt_q;
   reg [7:0]  op_q;
   reg        id_act_q;
   reg [2:0]  obit_q;
   reg [3:0]  dout_q;
   reg [7:0]  opc_q;
   reg        opc_vld_q;

   // device state
   reg [1:0]  st_q;
   reg [15:0] tmr_q;
   reg        busy_q;
   reg        sus_q;
   reg        sus_pend_q;
   reg [15:0] sus_cnt_q;
   reg [11:0] sus_sec_q;
   reg        sus_req_q;
   reg        res_req_q;

   wire       ck_rise;
   wire       ck_fall;
   wire       cs_rise;
   wire [5:0] cnt_step;
   wire [5:0] cnt_nx;
   wire [7:0] sh_nx;
   wire       opc_done;
   wire       end8;
   wire       sus_ok;
   wire       res_ok;

   // the second stage feeds logic; the third is a delayed copy used for edge detection
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         cs_s1_q <= 1'b1;
         cs_s2_q <= 1'b1;
         cs_s3_q <= 1'b1;
         ck_s1_q <= 1'b0;
         ck_s2_q <= 1'b0;
         ck_s3_q <= 1'b0;
         dq_s1_q <= 4'h0;
         dq_s2_q <= 4'h0;
      end
      else
      begin
         cs_s1_q <= cs_n_i;
         cs_s2_q <= cs_s1_q;
         cs_s3_q <= cs_s2_q;
         ck_s1_q <= sclk_i;
         ck_s2_q <= ck_s1_q;
         ck_s3_q <= ck_s2_q;
         dq_s1_q <= dq_i;
         dq_s2_q <= dq_s1_q;
      end
   end

   assign ck_rise  = ck_s2_q & ~ck_s3_q & ~cs_s2_q;
   assign ck_fall  = ~ck_s2_q & ck_s3_q & ~cs_s2_q;
   assign cs_rise  = cs_s2_q & ~cs_s3_q;
   assign cnt_step = quad_opcode_mode_i ? 6'h04 : 6'h01;
   assign cnt_nx   = (cnt_q >= `FSPD_CNT_MAX) ? cnt_q : cnt_q + cnt_step;
   assign sh_nx    = quad_opcode_mode_i ? {sh_q[3:0], dq_s2_q} :
                                          {sh_q[6:0], dq_s2_q[0]};
   assign opc_done = ck_rise && (cnt_nx == `FSPD_OPC_BITS) &&
                     (cnt_q != `FSPD_OPC_BITS);
   // local opcodes act on a rise right after bit eight; release with identifier read acts from bit 32 on
   assign end8     = cs_rise && (cnt_q == `FSPD_OPC_BITS);

   assign sus_ok = end8 && (op_q == `FSPD_OP_SUSPEND) && (st_q == ST_NORM)
                   && busy_q && !sus_q
                   && ((core_kind_i == `FSPD_KIND_SECBLK) ||
                       (core_kind_i == `FSPD_KIND_PAGE));
   // reset clears sus_q, so a power-lost suspension cannot resume
   assign res_ok = end8 && (op_q == `FSPD_OP_RESUME) && (st_q == ST_NORM)
                   && sus_q && !busy_q;

   // opcode capture and identifier shift-out
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         sh_q      <= 8'h00;
         cnt_q     <= 6'h00;
         op_q      <= 8'h00;
         id_act_q  <= `FSPD_RST_FLAG;
         obit_q    <= `FSPD_RST_OBIT;
         dout_q    <= 4'h0;
         opc_q     <= 8'h00;
         opc_vld_q <= `FSPD_RST_FLAG;
      end
      else
      begin
         opc_vld_q <= 1'b0;
         if (cs_s2_q)
         begin
            // any rise ends the frame, complete or not
            cnt_q    <= 6'h00;
            id_act_q <= 1'b0;
            obit_q   <= `FSPD_RST_OBIT;
         end
         else if (ck_rise)
         begin
            sh_q  <= sh_nx;
            cnt_q <= cnt_nx;
            if (opc_done)
            begin
               op_q <= sh_nx;
               // only normal operation forwards other opcodes, except program/erase ones while suspended
               if ((st_q == ST_NORM) && !is_local(sh_nx) &&
                   !(sus_q && is_pe(sh_nx)))
               begin
                  opc_q     <= sh_nx;
                  opc_vld_q <= 1'b1;
               end
            end
            if ((cnt_nx == `FSPD_ID_START) && (cnt_q != `FSPD_ID_START) &&
                (op_q == `FSPD_OP_RELEASE) &&
                (((st_q == ST_NORM) && !busy_q) || (st_q == ST_PD)))
               id_act_q <= 1'b1;
         end
         else if (ck_fall && id_act_q)
         begin
            // byte repeats endlessly until chip select rises
            if (quad_opcode_mode_i)
            begin
               dout_q <= obit_q[2] ? DEV_ID[7:4] : DEV_ID[3:0];
               obit_q <= obit_q ^ 3'h4;
            end
            else
            begin
               dout_q <= {2'b00, DEV_ID[obit_q], 1'b0};
               obit_q <= obit_q - 3'h1;
            end
         end
      end
   end

   // power-down sequencing
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         st_q  <= ST_NORM;
         tmr_q <= 16'h0000;
      end
      else
      begin
         case (st_q)
            ST_NORM:
            begin
               if (end8 && (op_q == `FSPD_OP_PWRDOWN))
               begin
                  st_q  <= ST_ENTER;
                  tmr_q <= 16'h0000;
               end
            end
            ST_ENTER:
            begin
               if (tmr_q >= `FSPD_DP_CYC - 1)
                  st_q <= ST_PD;
               tmr_q <= tmr_q + 16'h0001;
            end
            ST_PD:
            begin
               tmr_q <= 16'h0000;
               if (cs_rise && (op_q == `FSPD_OP_RELEASE) && id_act_q)
               begin
                  st_q  <= ST_REL;
                  tmr_q <= REL2_TMR;
               end
               else if (end8 && (op_q == `FSPD_OP_RELEASE))
                  st_q <= ST_REL;
            end
            ST_REL:
            begin
               // frames during the release wait are not recognized
               if (tmr_q >= `FSPD_RES1_CYC - 1)
                  st_q <= ST_NORM;
               tmr_q <= tmr_q + 16'h0001;
            end
            default:
            begin
               st_q  <= ST_NORM;
               tmr_q <= 16'h0000;
            end
         endcase
      end
   end

   // suspend and resume
   always @(posedge clk_i)
   begin
      if (rst_i)
      begin
         busy_q     <= `FSPD_RST_FLAG;
         sus_q      <= `FSPD_RST_FLAG;
         sus_pend_q <= `FSPD_RST_FLAG;
         sus_cnt_q  <= 16'h0000;
         sus_sec_q  <= 12'h000;
         sus_req_q  <= `FSPD_RST_FLAG;
         res_req_q  <= `FSPD_RST_FLAG;
      end
      else
      begin
         sus_req_q <= sus_ok;
         res_req_q <= res_ok;
         if (sus_ok)
         begin
            sus_q      <= 1'b1;
            sus_pend_q <= 1'b1;
            sus_cnt_q  <= 16'h0000;
            sus_sec_q  <= core_sector_i;
         end
         else if (res_ok)
         begin
            sus_q  <= 1'b0;
            busy_q <= 1'b1;
         end
         else if (sus_pend_q)
         begin
            // engine halt or latency expiry, whichever comes first
            sus_cnt_q <= sus_cnt_q + 16'h0001;
            if (core_halted_i || (sus_cnt_q >= SUS_CYC - 2))
            begin
               busy_q     <= 1'b0;
               sus_pend_q <= 1'b0;
            end
         end
         else if (!sus_q)
            busy_q <= core_busy_i;
      end
   end

   assign dq_o    = dout_q;
   assign dq_oe_o = (id_act_q && !cs_s2_q) ?
                    (quad_opcode_mode_i ? 4'hf : 4'h2) : 4'h0;
   assign opcode_o     = opc_q;
   assign opcode_vld_o = opc_vld_q;
   assign suspend_req_o    = sus_req_q;
   assign resume_req_o     = res_req_q;
   assign busy_flag_o      = busy_q;
   assign suspended_flag_o = sus_q;
   assign powerdown_o      = (st_q != ST_NORM);
   assign rd_allow_o = !sus_q || (rd_sector_i != sus_sec_q);

endmodule

`default_nettype wire

// [testbench/fspd_ctrl_sva.sv]
// Purpose: port-level property checks of the suspend/power-down control
// Assumes: one clock domain, synchronous active-high reset
// Notes:   SUS_CYC is handed on from the design through the bind
`timescale 1ns/10ps
`default_nettype none
module fspd_ctrl_sva
#(
   parameter int SUS_CYC = 20
)
(
   input wire logic       clk_i,
   input wire logic       rst_i,
   input wire logic [1:0] core_kind_i,
   input wire logic       suspend_req_o,
   input wire logic       resume_req_o,
   input wire logic [7:0] opcode_o,
   input wire logic       opcode_vld_o,
   input wire logic       busy_flag_o,
   input wire logic       suspended_flag_o,
   input wire logic       powerdown_o,
   input wire logic       rd_allow_o,
   input wire logic [3:0] dq_oe_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   chk_sus_accept: assert property (
      suspend_req_o |-> suspended_flag_o && !$past(suspended_flag_o)
      && $past(busy_flag_o)) else $error("suspend taken in wrong state");
   chk_sus_kind: assert property (
      suspend_req_o |-> $past(core_kind_i) inside {2'h1, 2'h2})
      else $error("suspend taken during chip erase");
   chk_sus_latency: assert property (
      $rose(suspended_flag_o) |-> ##[0:SUS_CYC] !busy_flag_o)
      else $error("busy not cleared within suspend latency");
   chk_resume_take: assert property (
      resume_req_o |-> !suspended_flag_o && busy_flag_o
      && $past(suspended_flag_o) && !$past(busy_flag_o))
      else $error("resume taken in wrong state");
   chk_reset_normal: assert property (
      $fell(rst_i) |-> !powerdown_o && !suspended_flag_o)
      else $error("not normal after reset");
   chk_pd_silent: assert property (
      opcode_vld_o |-> !powerdown_o) else $error("opcode in power-down");
   chk_sus_refuse: assert property (
      opcode_vld_o && suspended_flag_o |-> !(opcode_o inside {8'h01,
      8'h31, 8'h02, 8'h32, 8'h20, 8'h52, 8'hd8, 8'hc7, 8'h60}))
      else $error("write opcode passed while suspended");
   chk_rd_open: assert property (
      !suspended_flag_o |-> rd_allow_o) else $error("read blocked");
   chk_id_idle: assert property (
      dq_oe_o != 4'h0 |-> !busy_flag_o) else $error("id driven while busy");
endmodule
bind fspd_ctrl fspd_ctrl_sva #(.SUS_CYC(SUS_CYC)) i_chk (
   .clk_i(clk_i), .rst_i(rst_i), .core_kind_i(core_kind_i),
   .suspend_req_o(suspend_req_o), .resume_req_o(resume_req_o),
   .opcode_o(opcode_o), .opcode_vld_o(opcode_vld_o),
   .busy_flag_o(busy_flag_o), .suspended_flag_o(suspended_flag_o),
   .powerdown_o(powerdown_o), .rd_allow_o(rd_allow_o), .dq_oe_o(dq_oe_o));
`default_nettype wire

// [testbench/fspd_host.sv]
// Purpose: host flash controller model driving frames on the link
// Assumes: link clock of 48 ns, mode 0, stands low outside frames
// Notes:   cs rises right after the last counted bit of each frame
`timescale 1ns/10ps
`default_nettype none
module fspd_host
(
   input  wire logic       clk_i,
   input  wire logic       quad_i,
   input  wire logic [3:0] dq_i,
   output var  logic       cs_n_o,
   output var  logic       sclk_o,
   output var  logic [3:0] dq_o,
   output var  logic       oe_o
);
   initial
   begin
      cs_n_o = 1'b1;
      sclk_o = 1'b0;
      dq_o = 4'h0;
      oe_o = 1'b0;
   end
   task half;
      repeat (6) @(negedge clk_i);
   endtask
   // nb opcode bits, nd dummy bytes, nr id bytes read back
   task automatic frame(input logic [7:0] op, input int nb, input int nd,
                        input int nr, output logic [15:0] rd);
      int i;
      int w;
      logic [31:0] sh;
      begin
         w = quad_i ? 4 : 1;
         sh = {op, 24'h000000};
         rd = 16'h0000;
         cs_n_o = 1'b0;
         oe_o = 1'b1;
         for (i = 0; i < (nb + 8 * nd) / w; i++)
         begin
            dq_o = quad_i ? sh[31:28] : {3'h0, sh[31]};
            sh = sh << w;
            half;
            sclk_o = 1'b1;
            half;
            sclk_o = 1'b0;
         end
         oe_o = 1'b0;
         for (i = 0; i < 8 * nr / w; i++)
         begin
            half;
            sclk_o = 1'b1;
            rd = quad_i ? {rd[11:0], dq_i} : {rd[14:0], dq_i[1]};
            half;
            sclk_o = 1'b0;
         end
         half;
         cs_n_o = 1'b1;
         repeat (12) @(negedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// Purpose: self-checking bench of the suspend and power-down control
// Assumes: inputs change at the falling clock edge
// Notes:   short suspend latency keeps the run brief
`timescale 1ns/10ps
`default_nettype none
`include "fspd_regs.vh"
`define CHK(nm, ex, gt) \
   begin \
      cmp_count++; \
      if ((gt) !== (ex)) \
      begin \
         n_mismatch++; \
         $display("MISMATCH %s exp %0h got %0h", nm, ex, gt); \
      end \
   end
module testbench;
   localparam int SUSPENDED_FLAG = 20;
   localparam logic [71:0] REFUSED = 72'h01_31_02_32_20_52_d8_c7_60;
   logic clk = 1'b0, rst = 1'b1, cs_n, sclk, quad = 1'b0, h_oe, tog = 1'b0;
   logic core_busy = 1'b0, core_halted = 1'b0;
   logic [1:0] core_kind = 2'h0;
   logic [11:0] core_sector = 12'h010, rd_sector = 12'h000;
   logic [3:0] dq_w, dq_dut, dq_oe, h_dq;
   logic [7:0] opcode;
   logic vld, sus_req, res_req, busy, susp, pd, rd_ok;
   logic [15:0] rd;
   int n_mismatch = 0, cmp_count = 0, n_sus = 0, n_res = 0, n_fwd = 0;
   int n_oe = 0, s, i;
   // a released line shows a changing pattern, never the last value
   assign dq_w = (dq_oe & dq_dut) | (~dq_oe & (h_oe ? h_dq : {4{tog}}));
   always #2 clk = ~clk;
   fspd_ctrl #(.SUS_CYC(SUSPENDED_FLAG)) i_dut (.clk_i(clk), .rst_i(rst),
      .cs_n_i(cs_n), .sclk_i(sclk), .dq_i(dq_w), .dq_o(dq_dut),
      .dq_oe_o(dq_oe), .quad_opcode_mode_i(quad), .core_busy_i(core_busy),
      .core_kind_i(core_kind), .core_halted_i(core_halted),
      .core_sector_i(core_sector), .rd_sector_i(rd_sector),
      .suspend_req_o(sus_req), .resume_req_o(res_req), .opcode_o(opcode),
      .opcode_vld_o(vld), .busy_flag_o(busy), .suspended_flag_o(susp),
      .powerdown_o(pd), .rd_allow_o(rd_ok));
   fspd_host i_host (.clk_i(clk), .quad_i(quad), .dq_i(dq_w),
      .cs_n_o(cs_n), .sclk_o(sclk), .dq_o(h_dq), .oe_o(h_oe));
   always @(negedge clk)
   begin
      tog <= ~tog;
      core_halted <= sus_req;
      if (res_req)
         core_busy <= 1'b1;
   end
   always @(posedge clk)
   begin
      n_sus <= n_sus + sus_req;
      n_res <= n_res + res_req;
      n_fwd <= n_fwd + vld;
      n_oe <= n_oe + (dq_oe != 4'h0);
   end
   task cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   task op(input logic [7:0] c);
      i_host.frame(c, 8, 0, 0, rd);
   endtask
   task t_suspend;
      core_kind = 2'h1;
      core_busy = 1'b1;
      cyc(4);
      `CHK("busy", 1'b1, busy)
      s = n_sus;
      op(`FSPD_OP_SUSPEND);
      `CHK("susp", 1'b1, susp)
      `CHK("sus_req", s + 1, n_sus)
      cyc(SUSPENDED_FLAG);
      `CHK("busy_off", 1'b0, busy)
      rd_sector = 12'h010;
      cyc(1);
      `CHK("rd_same", 1'b0, rd_ok)
      rd_sector = 12'h011;
      cyc(1);
      `CHK("rd_other", 1'b1, rd_ok)
      s = n_fwd;
      for (i = 0; i < 9; i++)
         op(REFUSED[8 * i +: 8]);
      `CHK("refused", s, n_fwd)
      op(8'h03);
      `CHK("read_fwd", s + 1, n_fwd)
      `CHK("opcode", 8'h03, opcode)
      s = n_sus;
      op(`FSPD_OP_SUSPEND);
      `CHK("sus_again", s, n_sus)
      s = n_res;
      op(`FSPD_OP_RESUME);
      `CHK("res_susp", 1'b0, susp)
      `CHK("res_busy", 1'b1, busy)
      `CHK("res_req", s + 1, n_res)
      op(`FSPD_OP_RESUME);
      `CHK("res_busy_ign", s + 1, n_res)
      cyc(SUSPENDED_FLAG);
      core_busy = 1'b0;
      cyc(4);
      `CHK("busy_done", 1'b0, busy)
   endtask
   task t_chip;
      core_kind = 2'h3;
      core_busy = 1'b1;
      s = n_oe;
      i_host.frame(`FSPD_OP_RELEASE, 8, 3, 1, rd);
      `CHK("id_busy", s, n_oe)
      s = n_sus;
      op(`FSPD_OP_SUSPEND);
      `CHK("chip_sus", s, n_sus)
      core_kind = 2'h1;
      core_busy = 1'b0;
      cyc(4);
      op(`FSPD_OP_SUSPEND);
      `CHK("idle_sus", s, n_sus)
   endtask
   task t_loss;
      core_kind = 2'h2;
      core_busy = 1'b1;
      op(`FSPD_OP_SUSPEND);
      `CHK("loss_susp", 1'b1, susp)
      core_busy = 1'b0;
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      cyc(5);
      `CHK("loss_clear", 1'b0, susp)
      `CHK("loss_pd", 1'b0, pd)
      s = n_res;
      op(`FSPD_OP_RESUME);
      `CHK("loss_res", s, n_res)
   endtask
   task t_pdown;
      i_host.frame(`FSPD_OP_PWRDOWN, 7, 0, 0, rd);
      cyc(`FSPD_DP_CYC + 50);
      `CHK("pd_short", 1'b0, pd)
      op(`FSPD_OP_PWRDOWN);
      `CHK("pd_on", 1'b1, pd)
      cyc(`FSPD_DP_CYC + 50);
      s = n_fwd;
      op(8'h05);
      `CHK("pd_ignore", s, n_fwd)
      op(`FSPD_OP_RELEASE);
      cyc(`FSPD_RES1_CYC - 60);
      `CHK("pd_wait", 1'b1, pd)
      cyc(80);
      `CHK("pd_off", 1'b0, pd)
   endtask
   task t_id;
      i_host.frame(`FSPD_OP_RELEASE, 8, 3, 2, rd);
      `CHK("id_spi", {`FSPD_DEV_ID, `FSPD_DEV_ID}, rd)
      quad = 1'b1;
      cyc(4);
      op(`FSPD_OP_PWRDOWN);
      cyc(`FSPD_DP_CYC + 50);
      i_host.frame(`FSPD_OP_RELEASE, 8, 3, 2, rd);
      `CHK("id_quad", {`FSPD_DEV_ID, `FSPD_DEV_ID}, rd)
      cyc(`FSPD_RES2_CYC - 60);
      `CHK("id_wait", 1'b1, pd)
      cyc(80);
      `CHK("id_off", 1'b0, pd)
   endtask
   task wrap_up;
      if (n_mismatch == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial
   begin
      #120000;
      n_mismatch++;
      wrap_up;
   end
   initial
   begin
      cyc(16);
      rst = 1'b0;
      cyc(4);
      t_suspend;
      t_chip;
      t_loss;
      t_pdown;
      t_id;
      wrap_up;
   end
endmodule
`default_nettype wire
